// *** src/dhi_defs.svh ***
// Constants of the display host interface front end
`ifndef DHI_DEFS_SVH
`define DHI_DEFS_SVH
`define DHI_CMD_DISP_OFF 8'hae
`define DHI_CMD_DISP_ON 8'haf
`define DHI_I2C_ADDR_HI 6'h1e
`define DHI_CTRL_CO_BIT 7
`define DHI_CTRL_DC_BIT 6
`define DHI_SER_CLK_BIT 0
`define DHI_SER_DATA_BIT 1
`define DHI_SDA_TIE_BIT 2
`define DHI_STAT_OFF_BIT 6
`define DHI_DISP_ON_RESET 1'b0
`define DHI_BIT_CNT_4W 4'h7
`define DHI_BIT_CNT_3W 4'h8
`define DHI_BIT_CNT_ACK 4'h8
`define DHI_BIT_CNT_END 4'h9
`endif

// *** src/dhi_pkg.sv ***
// Types of the display host interface front end
package dhi_pkg;
    // Host port selected by the straps
    typedef enum logic [2:0] {
        DHI_SER4, DHI_PAR_EN, DHI_I2C, DHI_PAR_SEP, DHI_SER3, DHI_NONE
    } dhi_mode_type;
    // I2C receive states
    typedef enum logic [2:0] {
        DHI_I_IDLE, DHI_I_ADDR, DHI_I_CTRL, DHI_I_DATA, DHI_I_SKIP
    } dhi_i2c_type;
    // One routed byte
    typedef struct packed {
        logic is_data;
        logic [7:0] value;
    } dhi_byte_type;
    // Host side pins sampled together
    typedef struct packed {
        logic [2:0] strap;
        logic cs_n;
        logic dc;
        logic strobe1;
        logic strobe2;
        logic [7:0] bus;
    } dhi_pins_type;
endpackage : dhi_pkg

// *** src/dhi_buffer.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dhi_buffer #(
    parameter int WIDTH = 9
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem_next [2];
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic push;
    logic pop;
    logic [1:0] wr_idx;
    logic valid_reg;
    logic valid_next;

    // Entry 0 is always the head so the output is a plain flop
    always_comb begin
        in_ready = (count_reg != 2'h2);
        push = in_valid && in_ready;
        pop = (count_reg != 2'h0) && out_ready;
        mem_next[0] = mem_reg[0];
        mem_next[1] = mem_reg[1];
        if (pop) begin
            mem_next[0] = mem_reg[1];
        end
        wr_idx = count_reg - {1'b0, pop};
        if (push) begin
            mem_next[wr_idx[0]] = in_data;
        end
        count_next = count_reg + {1'b0, push} - {1'b0, pop};
        // Valid kept in its own flop so the port is a plain register
        valid_next = (count_next != 2'h0);
    end

    // Storage registers
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= 2'h0;
            valid_reg <= 1'b0;
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else begin
            count_reg <= count_next;
            valid_reg <= valid_next;
            mem_reg[0] <= mem_next[0];
            mem_reg[1] <= mem_next[1];
        end
    end

    assign out_valid = valid_reg;
    assign out_data = mem_reg[0];
endmodule : dhi_buffer
`default_nettype wire

// *** src/dhi_front_end.sv ***
// Host interface front end: five host ports into one byte stream
`timescale 1ns/1ps
`default_nettype none
`include "dhi_defs.svh"
module dhi_front_end
    import dhi_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic hw_reset_n,
    input wire logic iface_strap_bit0,
    input wire logic iface_strap_bit1,
    input wire logic iface_strap_bit2,
    input wire logic chip_sel_n,
    input wire logic data_cmd_sel,
    input wire logic ctl_strobe1,
    input wire logic ctl_strobe2,
    input wire logic [7:0] bus_in,
    output logic [7:0] bus_out,
    output logic [7:0] bus_oe_n,
    output logic byte_valid,
    input wire logic byte_ready,
    output dhi_byte_type byte_out,
    output logic display_on,
    output logic overrun
);
    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    dhi_pins_type pins_raw, pins_s1, pins_s2, pins_d;
    logic hwr_s1, hwr_s2, rst;
    assign pins_raw = '{strap: {iface_strap_bit0, iface_strap_bit1,
        iface_strap_bit2}, cs_n: chip_sel_n, dc: data_cmd_sel,
        strobe1: ctl_strobe1, strobe2: ctl_strobe2, bus: bus_in};

    // Two flops per pin; the third stage gives edges
    always_ff @(posedge clk) begin
        if (reset) begin
            hwr_s1 <= 1'b0;
            hwr_s2 <= 1'b0;
            pins_s1 <= '1;
            pins_s2 <= '1;
            pins_d <= '1;
        end else begin
            hwr_s1 <= hw_reset_n;
            hwr_s2 <= hwr_s1;
            pins_s1 <= pins_raw;
            pins_s2 <= pins_s1;
            pins_d <= pins_s2;
        end
    end
    assign rst = reset || !hwr_s2;

    // ****************************************************
    // Decoding helpers
    // ****************************************************
    // strap decode
    function automatic dhi_mode_type strap_mode(input logic [2:0] s);
        case (s)
            3'h0: strap_mode = DHI_SER4;
            3'h1: strap_mode = DHI_PAR_EN;
            3'h2: strap_mode = DHI_I2C;
            3'h3: strap_mode = DHI_PAR_SEP;
            3'h4: strap_mode = DHI_SER3;
            default: strap_mode = DHI_NONE;
        endcase
    endfunction : strap_mode

    // Argument bytes that follow a command, so they are never decoded
    function automatic logic [2:0] arg_count(input logic [7:0] c);
        case (c)
            8'h81, 8'h20: arg_count = 3'h1;
            8'h21, 8'h22: arg_count = 3'h2;
            8'h26, 8'h27: arg_count = 3'h6;
            8'h29, 8'h2a: arg_count = 3'h5;
            default: arg_count = 3'h0;
        endcase
    endfunction : arg_count

    // ****************************************************
    // Receive state
    // ****************************************************
    dhi_mode_type mode_reg, mode_next;
    dhi_i2c_type i2c_reg, i2c_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] cnt_reg, cnt_next;
    logic ser_dc_reg, ser_dc_next;
    logic co_reg, co_next, cdc_reg, cdc_next;
    logic sda_drv_reg, sda_drv_next;
    logic pend_valid_reg, pend_valid_next;
    dhi_byte_type pend_reg, pend_next;
    logic [7:0] bus_out_reg, bus_out_next, oe_n_reg, oe_n_next;
    logic overrun_reg, overrun_next;
    logic disp_on_reg, disp_on_next;
    logic [2:0] args_reg, args_next;
    logic new_valid;
    dhi_byte_type new_byte;
    logic buf_ready, buf_valid;
    dhi_byte_type buf_data;
    logic scl_rise, scl_fall, sda, start_c, stop_c, wr_en, wr_sep;
    logic rd_en, rd_sep, consume;

    always_comb begin
        scl_rise = pins_s2.bus[`DHI_SER_CLK_BIT]
            && !pins_d.bus[`DHI_SER_CLK_BIT];
        scl_fall = !pins_s2.bus[`DHI_SER_CLK_BIT]
            && pins_d.bus[`DHI_SER_CLK_BIT];
        sda = pins_s2.bus[`DHI_SER_DATA_BIT];
        start_c = pins_s2.bus[`DHI_SER_CLK_BIT]
            && pins_d.bus[`DHI_SER_CLK_BIT]
            && !sda && pins_d.bus[`DHI_SER_DATA_BIT];
        stop_c = pins_s2.bus[`DHI_SER_CLK_BIT]
            && pins_d.bus[`DHI_SER_CLK_BIT]
            && sda && !pins_d.bus[`DHI_SER_DATA_BIT];
        // strobe one is direction or write enable
        wr_en = !pins_s2.strobe2 && pins_d.strobe2 && !pins_d.strobe1;
        wr_sep = pins_s2.strobe1 && !pins_d.strobe1;
        // strobe two is transfer or read enable
        rd_en = pins_s2.strobe1 && pins_s2.strobe2;
        rd_sep = !pins_s2.strobe2;
    end

    // Next state of all port logic
    always_comb begin
        mode_next = strap_mode(pins_s2.strap);
        i2c_next = i2c_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        ser_dc_next = ser_dc_reg;
        co_next = co_reg;
        cdc_next = cdc_reg;
        sda_drv_next = sda_drv_reg;
        new_valid = 1'b0;
        new_byte = '{is_data: 1'b0, value: 8'h00};
        bus_out_next = 8'h00;
        oe_n_next = 8'hff;
        // chip select high drops any transfer in flight
        if (pins_s2.cs_n) begin
            cnt_next = 4'h0;
            i2c_next = DHI_I_IDLE;
            sda_drv_next = 1'b0;
        end else begin
            case (mode_reg)
                // parallel byte capture and status read
                DHI_PAR_EN, DHI_PAR_SEP: begin
                    if ((mode_reg == DHI_PAR_EN) ? wr_en : wr_sep) begin
                        new_valid = 1'b1;
                        new_byte = '{is_data: pins_s2.dc,
                            value: pins_s2.bus};
                    end
                    if ((mode_reg == DHI_PAR_EN) ? rd_en : rd_sep) begin
                        oe_n_next = 8'h00;
                        bus_out_next[`DHI_STAT_OFF_BIT] = !disp_on_reg;
                    end
                end
                // serial clock on bit 0, data on bit 1
                DHI_SER4, DHI_SER3: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda};
                        cnt_next = cnt_reg + 4'h1;
                        // first of nine bits is the byte type
                        if (mode_reg == DHI_SER3 && cnt_reg == 4'h0) begin
                            ser_dc_next = sda;
                            shift_next = shift_reg;
                        end
                        if (cnt_reg == ((mode_reg == DHI_SER4) ?
                                `DHI_BIT_CNT_4W : `DHI_BIT_CNT_3W)) begin
                            cnt_next = 4'h0;
                            new_valid = 1'b1;
                            new_byte = '{is_data: (mode_reg == DHI_SER4) ?
                                pins_s2.dc : ser_dc_reg,
                                value: {shift_reg[6:0], sda}};
                        end
                    end
                end
                // SDA on bits 2 and 1, SCL on bit 0
                DHI_I2C: begin
                    if (start_c) begin
                        i2c_next = DHI_I_ADDR;
                        cnt_next = 4'h0;
                    end else if (stop_c) begin
                        i2c_next = DHI_I_IDLE;
                    end else if (i2c_reg != DHI_I_IDLE) begin
                        if (scl_rise && cnt_reg < `DHI_BIT_CNT_ACK) begin
                            shift_next = {shift_reg[6:0], sda};
                            cnt_next = cnt_reg + 4'h1;
                        end else if (scl_rise) begin
                            cnt_next = `DHI_BIT_CNT_END;
                        end else if (scl_fall
                                && cnt_reg == `DHI_BIT_CNT_ACK) begin
                            case (i2c_reg)
                                DHI_I_ADDR: begin
                                    // select pin is address bit 0
                                    if (shift_reg == {`DHI_I2C_ADDR_HI,
                                            pins_s2.dc, 1'b0}) begin
                                        sda_drv_next = 1'b1;
                                        i2c_next = DHI_I_CTRL;
                                    end else begin
                                        i2c_next = DHI_I_SKIP;
                                    end
                                end
                                DHI_I_CTRL: begin
                                    sda_drv_next = 1'b1;
                                    co_next = shift_reg[`DHI_CTRL_CO_BIT];
                                    cdc_next = shift_reg[`DHI_CTRL_DC_BIT];
                                    i2c_next = DHI_I_DATA;
                                end
                                DHI_I_DATA: begin
                                    // Refuse with a nack while stalled
                                    if (pend_valid_reg) begin
                                        i2c_next = DHI_I_SKIP;
                                    end else begin
                                        sda_drv_next = 1'b1;
                                        new_valid = 1'b1;
                                        new_byte = '{is_data: cdc_reg,
                                            value: shift_reg};
                                        if (co_reg) begin
                                            i2c_next = DHI_I_CTRL;
                                        end
                                    end
                                end
                                default: i2c_next = DHI_I_SKIP;
                            endcase
                        end else if (scl_fall
                                && cnt_reg == `DHI_BIT_CNT_END) begin
                            sda_drv_next = 1'b0;
                            cnt_next = 4'h0;
                        end
                    end
                    if (sda_drv_next) begin
                        oe_n_next[`DHI_SER_DATA_BIT] = 1'b0;
                        oe_n_next[`DHI_SDA_TIE_BIT] = 1'b0;
                    end
                end
                default: cnt_next = 4'h0;
            endcase
        end
    end

    // single holding stage ahead of the buffer keeps order
    always_comb begin
        pend_valid_next = pend_valid_reg && !buf_ready;
        pend_next = pend_reg;
        overrun_next = overrun_reg;
        if (new_valid) begin
            // Host strobes cannot be stalled, so a full path drops
            if (pend_valid_next) begin
                overrun_next = 1'b1;
            end else begin
                pend_valid_next = 1'b1;
                pend_next = new_byte;
            end
        end
    end

    // Display on/off follows commands as the decoder consumes them
    always_comb begin
        consume = buf_valid && byte_ready && !buf_data.is_data;
        disp_on_next = disp_on_reg;
        args_next = args_reg;
        if (consume) begin
            if (args_reg != 3'h0) begin
                args_next = args_reg - 3'h1;
            end else begin
                args_next = arg_count(buf_data.value);
                // off command puts the panel to sleep
                if (buf_data.value == `DHI_CMD_DISP_OFF) begin
                    disp_on_next = 1'b0;
                end
                if (buf_data.value == `DHI_CMD_DISP_ON) begin
                    disp_on_next = 1'b1;
                end
            end
        end
    end

    // all state, display off included, takes reset values
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= DHI_NONE;
            i2c_reg <= DHI_I_IDLE;
            shift_reg <= 8'h00;
            cnt_reg <= 4'h0;
            ser_dc_reg <= 1'b0;
            co_reg <= 1'b0;
            cdc_reg <= 1'b0;
            sda_drv_reg <= 1'b0;
            pend_valid_reg <= 1'b0;
            pend_reg <= '0;
            bus_out_reg <= 8'h00;
            oe_n_reg <= 8'hff;
            overrun_reg <= 1'b0;
            disp_on_reg <= `DHI_DISP_ON_RESET;
            args_reg <= 3'h0;
        end else begin
            mode_reg <= mode_next;
            i2c_reg <= i2c_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            ser_dc_reg <= ser_dc_next;
            co_reg <= co_next;
            cdc_reg <= cdc_next;
            sda_drv_reg <= sda_drv_next;
            pend_valid_reg <= pend_valid_next;
            pend_reg <= pend_next;
            bus_out_reg <= bus_out_next;
            oe_n_reg <= oe_n_next;
            overrun_reg <= overrun_next;
            disp_on_reg <= disp_on_next;
            args_reg <= args_next;
        end
    end

    dhi_buffer #(.WIDTH($bits(dhi_byte_type))) u_buffer (
        .clk(clk),
        .rst(rst),
        .in_valid(pend_valid_reg),
        .in_ready(buf_ready),
        .in_data(pend_reg),
        .out_valid(buf_valid),
        .out_ready(byte_ready),
        .out_data(buf_data)
    );

    assign bus_out = bus_out_reg;
    assign bus_oe_n = oe_n_reg;
    assign byte_valid = buf_valid;
    assign byte_out = buf_data;
    assign display_on = disp_on_reg;
    assign overrun = overrun_reg;

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_cs_gate;
        pins_s2.cs_n && !pend_valid_reg |=> !pend_valid_reg;
    endproperty
    a_cs_gate: assert property (p_cs_gate) else $error("byte with cs high");
    property p_reset;
        !hwr_s2 |=> !display_on && !byte_valid && &bus_oe_n;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_dc_par;
        mode_reg == DHI_PAR_SEP && wr_sep && !pins_s2.cs_n
            && !pend_valid_reg && !rst
            |=> pend_valid_reg && pend_reg.is_data == $past(pins_s2.dc);
    endproperty
    a_dc_par: assert property (p_dc_par) else $error("byte type wrong");
    property p_sa0;
        i2c_reg == DHI_I_ADDR && scl_fall && cnt_reg == 4'h8 && !pins_s2.cs_n
            && shift_reg[1] != pins_s2.dc |=> !sda_drv_reg;
    endproperty
    a_sa0: assert property (p_sa0) else $error("acked wrong address");
    property p_off;
        consume && args_reg == 3'h0 && buf_data.value == 8'hae && !rst
            |=> !display_on;
    endproperty
    a_off: assert property (p_off) else $error("display stayed on");
    property p_on;
        consume && args_reg == 3'h0 && buf_data.value == 8'haf && !rst
            ##1 !rst |=> display_on;
    endproperty
    a_on: assert property (p_on) else $error("display stayed off");
    property p_scl_free;
        mode_reg == DHI_I2C |=> bus_oe_n[0];
    endproperty
    a_scl_free: assert property (p_scl_free) else $error("SCL driven");
    property p_ser_quiet;
        mode_reg inside {DHI_SER4, DHI_SER3} && !rst |=> bus_oe_n == 8'hff;
    endproperty
    a_ser_quiet: assert property (p_ser_quiet) else $error("serial drove bus");
    property p_hold;
        pend_valid_reg && !buf_ready && !rst |=> pend_valid_reg && $stable(pend_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled byte lost");
    c_on: cover property (consume && buf_data.value == 8'haf);
    c_i2c_ack: cover property (sda_drv_reg && i2c_reg == DHI_I_DATA);
    c_full: cover property (pend_valid_reg && !buf_ready);
    c_overrun: cover property ($rose(overrun_reg));
endmodule : dhi_front_end
`default_nettype wire

// *** dv/dhi_host_model.sv ***
// Host model that drives the front end's pins
`timescale 1ns/1ps
`default_nettype none
module dhi_host_model (
    input wire logic clk,
    output logic [2:0] strap,
    output logic cs_n,
    output logic dc,
    output logic st1,
    output logic st2,
    output logic [7:0] bus_in,
    input wire logic [7:0] bus_out,
    input wire logic [7:0] bus_oe_n
);
    // ****************
    // Pin driving
    // ****************
    logic [7:0] drv = 8'h00;
    initial begin
        strap = 3'h0;
        cs_n = 1'b1;
        dc = 1'b0;
        st1 = 1'b0;
        st2 = 1'b0;
    end
    assign bus_in = (drv & bus_oe_n) | (bus_out & ~bus_oe_n);
    // Every phase lasts four cycles, above the three the syncs need
    task automatic ph();
        repeat (4) @(posedge clk);
    endtask : ph
    task automatic setup(input logic [2:0] m, input logic s);
        strap <= m;
        st1 <= s;
        st2 <= s;
        ph();
        ph();
    endtask : setup
    task automatic par_wr(input logic sep, input logic d_c,
                          input logic [7:0] v, input logic sel_n);
        cs_n <= sel_n;
        dc <= d_c;
        drv <= v;
        if (sep) st1 <= 1'b0;
        else st2 <= 1'b1;
        ph();
        if (sep) st1 <= 1'b1;
        else st2 <= 1'b0;
        ph();
        cs_n <= 1'b1;
        drv <= ~v;
        ph();
    endtask : par_wr
    // status read in either parallel mode
    task automatic par_rd(input logic sep, output logic [7:0] oe,
                          output logic [7:0] v);
        cs_n <= 1'b0;
        st1 <= 1'b1;
        st2 <= !sep;
        ph();
        ph();
        oe = bus_oe_n;
        v = bus_out;
        st1 <= sep;
        st2 <= sep;
        cs_n <= 1'b1;
        ph();
    endtask : par_rd
    // serial frame, msb first, clock still outside
    task automatic ser_wr(input logic three, input logic d_c,
                          input logic [7:0] v);
        logic [8:0] s;
        s = {d_c, v};
        cs_n <= 1'b0;
        dc <= three ? 1'b0 : d_c;
        ph();
        for (int i = three ? 8 : 7; i >= 0; i--) begin
            drv <= {6'h00, s[i], 1'b0};
            ph();
            drv[0] <= 1'b1;
            ph();
        end
        drv <= {6'h00, ~s[0], 1'b0};
        ph();
        cs_n <= 1'b1;
        ph();
    endtask : ser_wr
    // bits 2 and 1 joined as data, bit 0 clock
    task automatic i2c_pin(input logic scl, input logic sda);
        drv <= {5'h00, sda, sda, scl};
        ph();
    endtask : i2c_pin
    // three bytes framed by start and stop
    task automatic i2c_wr(input logic sa, input logic [23:0] b,
                          output logic [2:0] nack);
        cs_n <= 1'b0;
        dc <= sa;
        i2c_pin(1'b1, 1'b1);
        i2c_pin(1'b1, 1'b0);
        i2c_pin(1'b0, 1'b0);
        for (int k = 2; k >= 0; k--) begin
            for (int i = 7; i >= 0; i--) begin
                i2c_pin(1'b0, b[8*k+i]);
                i2c_pin(1'b1, b[8*k+i]);
                i2c_pin(1'b0, b[8*k+i]);
            end
            i2c_pin(1'b0, 1'b1);
            i2c_pin(1'b1, 1'b1);
            nack[k] = bus_in[1];
            i2c_pin(1'b0, 1'b1);
        end
        i2c_pin(1'b0, 1'b0);
        i2c_pin(1'b1, 1'b0);
        i2c_pin(1'b1, 1'b1);
        // Deselect lasts a phase so a following call sees it high
        cs_n <= 1'b1;
        ph();
    endtask : i2c_wr
endmodule : dhi_host_model
`default_nettype wire

// *** dv/test_display_host_interface_front_end.sv ***
// Self-checking bench of the display host interface front end
`timescale 1ns/1ps
`default_nettype none
module test_display_host_interface_front_end
    import dhi_pkg::*;
;
    // ****************
    // Bench
    // ****************
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hw_reset_n = 1'b1;
    logic byte_ready = 1'b1;
    logic [2:0] strap;
    logic [2:0] nack;
    logic cs_n, dc, st1, st2, byte_valid, display_on, overrun;
    logic [7:0] bus_in, bus_out, bus_oe_n, oe, rv;
    dhi_byte_type byte_out;
    dhi_byte_type exp_q[$];
    int error_cnt = 0;
    int checks_done = 0;
    logic [31:0] rnd_state = 32'h8;
    dhi_front_end u_dut (.clk(clk), .reset(reset), .hw_reset_n(hw_reset_n),
        .iface_strap_bit0(strap[2]), .iface_strap_bit1(strap[1]),
        .iface_strap_bit2(strap[0]), .chip_sel_n(cs_n), .data_cmd_sel(dc),
        .ctl_strobe1(st1), .ctl_strobe2(st2), .bus_in(bus_in),
        .bus_out(bus_out), .bus_oe_n(bus_oe_n), .byte_valid(byte_valid),
        .byte_ready(byte_ready), .byte_out(byte_out),
        .display_on(display_on), .overrun(overrun));
    dhi_host_model u_host (.clk(clk), .strap(strap), .cs_n(cs_n), .dc(dc),
        .st1(st1), .st2(st2), .bus_in(bus_in), .bus_out(bus_out),
        .bus_oe_n(bus_oe_n));
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [7:0] rnd8();
        rnd_state ^= rnd_state << 13;
        rnd_state ^= rnd_state >> 17;
        rnd_state ^= rnd_state << 5;
        return rnd_state[7:0];
    endfunction : rnd8
    task automatic tally_and_finish();
        if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic cmp_val(input string n, input logic [7:0] e,
                           input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : cmp_val
    // An empty queue means the byte was never sent
    task automatic cmp_byte(input dhi_byte_type s);
        dhi_byte_type e;
        e = (exp_q.size() == 0) ? 9'bx : exp_q.pop_front();
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED byte_out expected %h seen %h", e, s);
        end
    endtask : cmp_byte
    task automatic pw(input logic sep, input logic d_c, input logic [7:0] v);
        exp_q.push_back({d_c, v});
        u_host.par_wr(sep, d_c, v, 1'b0);
    endtask : pw
    task automatic sw(input logic three, input logic d_c,
                      input logic [7:0] v);
        exp_q.push_back({d_c, v});
        u_host.ser_wr(three, d_c, v);
    endtask : sw
    // Bounded wait until every noted byte has come out
    task automatic drain();
        int n;
        n = 0;
        while ((exp_q.size() != 0 || byte_valid !== 1'b0) && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) begin
            error_cnt++;
            $display("CHECK FAILED drain expected empty seen stuck");
            tally_and_finish();
        end
        repeat (3) @(posedge clk);
    endtask : drain
    // Every accepted byte is checked against the oldest note
    always @(posedge clk) begin
        if (byte_valid === 1'b1 && byte_ready === 1'b1) cmp_byte(byte_out);
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        cmp_val("display_on", 8'h00, {7'h00, display_on});
        cmp_val("bus_oe_n", 8'hff, bus_oe_n);
        u_host.setup(3'b011, 1'b1);
        pw(1'b1, 1'b0, 8'haf);
        for (int i = 0; i < 3; i++) pw(1'b1, 1'b1, rnd8());
        u_host.par_wr(1'b1, 1'b1, rnd8(), 1'b1);
        drain();
        cmp_val("display_on", 8'h01, {7'h00, display_on});
        // Consumer stalls: three bytes are held, the fourth is lost
        byte_ready <= 1'b0;
        for (int i = 0; i < 3; i++) pw(1'b1, 1'b1, rnd8());
        u_host.par_wr(1'b1, 1'b1, rnd8(), 1'b0);
        cmp_val("overrun", 8'h01, {7'h00, overrun});
        byte_ready <= 1'b1;
        drain();
        u_host.par_rd(1'b1, oe, rv);
        cmp_val("bus_oe_n", 8'h00, oe);
        cmp_val("bus_out", 8'h00, rv);
        // Strap code outside the table must take nothing
        u_host.setup(3'b101, 1'b0);
        u_host.par_wr(1'b0, 1'b1, rnd8(), 1'b0);
        u_host.setup(3'b001, 1'b0);
        pw(1'b0, 1'b0, 8'hae);
        pw(1'b0, 1'b1, rnd8());
        drain();
        cmp_val("display_on", 8'h00, {7'h00, display_on});
        u_host.par_rd(1'b0, oe, rv);
        cmp_val("bus_oe_n", 8'h00, oe);
        cmp_val("bus_out", 8'h40, rv);
        for (int m = 0; m < 2; m++) begin
            u_host.setup(m ? 3'b000 : 3'b100, 1'b0);
            sw(m == 0, 1'b1, rnd8());
            sw(m == 0, 1'b0, m ? 8'haf : 8'hae);
            drain();
            cmp_val("display_on", 8'(m), {7'h00, display_on});
        end
        hw_reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        cmp_val("display_on", 8'h00, {7'h00, display_on});
        cmp_val("overrun", 8'h00, {7'h00, overrun});
        hw_reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        u_host.setup(3'b010, 1'b0);
        rv = rnd8();
        exp_q.push_back({1'b1, rv});
        u_host.i2c_wr(1'b1, {8'h7a, 8'h40, rv}, nack);
        cmp_val("i2c_nack", 8'h00, {5'h00, nack});
        u_host.i2c_wr(1'b0, {8'h7a, 8'h40, rv}, nack);
        cmp_val("i2c_nack", 8'h07, {5'h00, nack});
        drain();
        tally_and_finish();
    end
endmodule : test_display_host_interface_front_end
`default_nettype wire
